// ---- logic/flash_wel_protect_resume_cmds.sv ----
// write-enable, sector protect, suspend and resume command decoder of a serial flash
// Operation
// - resume is opcode D0h, extra bytes ignored
// - resume does not consult the write latch
// - resume clears suspend flag, reports busy
// - short or misaligned resume frame does nothing
// - program resumes before erase when both suspended
// - suspend ignored during resume latency
// - opcode 06h sets write latch at frame end
// - short or misaligned enable/disable leaves latch
// - protected commands refused without write latch
// - opcode 04h clears write latch at frame end
// - one protect bit per sector, reset protected
// - protected sector rejects program and erase
// - protect is 36h plus three address bytes
// - protect sets sector bit, clears write latch
// - short protect aborts, bit kept, latch cleared
// - locked registers: protect ignored, latch cleared
// - suspend B0h sets suspend flag, reports ready
`timescale 1ns/100ps
module flash_wel_protect_resume_cmds
  import flash_cmd_pkg::*;
#(
  parameter int SECTORS = NUM_SECTORS
) (
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_RST_N,
  input  wire logic              I_CE,
  input  wire logic              I_SPI_SCK,
  input  wire logic              I_SPI_CS_N,
  input  wire logic              I_SPI_MOSI,
  input  wire logic              I_PROTECTION_REGS_LOCKED,
  input  wire logic              I_PROG_START,
  input  wire logic              I_ERASE_START,
  input  wire logic              I_PROG_DONE,
  input  wire logic              I_ERASE_DONE,
  input  wire logic [ADDR_W-1:0] I_TARGET_ADDR,
  output logic                   O_WRITE_ENABLE_LATCH,
  output logic                   O_PROGRAM_SUSPENDED_FLAG,
  output logic                   O_ERASE_SUSPENDED_FLAG,
  output logic                   O_READY_BUSY_FLAG,
  output logic                   O_RESUMING,
  output logic                   O_PROG_RESUME,
  output logic                   O_ERASE_RESUME,
  output logic                   O_PROG_SUSPEND,
  output logic                   O_ERASE_SUSPEND,
  output logic                   O_WRITE_ALLOWED,
  output logic [SECTORS-1:0]     O_PROTECT_BITS
);
  frame_if fr ();

  frame_t                  state_ff;
  frame_t                  nxt_state;
  logic                    cs_meta_ff;
  logic                    cs_sync_ff;
  logic                    tog_meta_ff;
  logic                    tog_sync_ff;
  logic                    tog_seen_ff;
  logic                    locked_meta_ff;
  logic                    locked_ff;
  logic                    wel_ff;
  logic [NUM_OPS-1:0]      run_ff;
  logic [NUM_OPS-1:0]      susp_ff;
  logic [NUM_OPS-1:0]      start;
  logic [NUM_OPS-1:0]      done;
  logic [NUM_OPS-1:0]      resume_sel;
  logic [NUM_OPS-1:0]      suspend_sel;
  logic [NUM_OPS-1:0]      resume_pls_ff;
  logic [NUM_OPS-1:0]      suspend_pls_ff;
  logic [RESUME_CNT_W-1:0] resume_cnt_ff;
  logic [SECTORS-1:0]      prot_ff;
  logic                    allowed_ff;
  logic                    dec;
  logic                    fresh;
  logic                    opc_whole;
  logic                    aligned;
  logic                    do_resume;
  logic                    do_suspend;
  logic                    prot_seen;
  logic                    do_protect;
  logic [SECTOR_W-1:0]     sector;
  logic [SECTOR_W-1:0]     tgt_sector;

  // link-clock shifter, fields stay still while chip select is high
  spi_frame_shifter u_shift (
    .i_sck   (I_SPI_SCK),
    .i_cs_n  (I_SPI_CS_N),
    .i_mosi  (I_SPI_MOSI),
    .i_rst_n (I_RST_N),
    .lnk     (fr.link)
  );

  // two-stage synchronisers for chip select, frame toggle and lock level
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      cs_meta_ff     <= 1'b1;
      cs_sync_ff     <= 1'b1;
      tog_meta_ff    <= 1'b0;
      tog_sync_ff    <= 1'b0;
      locked_meta_ff <= 1'b0;
      locked_ff      <= 1'b0;
    end else if (I_CE) begin
      cs_meta_ff     <= I_SPI_CS_N;
      cs_sync_ff     <= cs_meta_ff;
      tog_meta_ff    <= fr.frame_tog;
      tog_sync_ff    <= tog_meta_ff;
      locked_meta_ff <= I_PROTECTION_REGS_LOCKED;
      locked_ff      <= locked_meta_ff;
    end
  end

  // frame tracker: decode lands one cycle after synchronised chip select rises
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      FR_IDLE:   nxt_state = cs_sync_ff ? FR_IDLE : FR_ACTIVE;
      FR_ACTIVE: nxt_state = cs_sync_ff ? FR_DECODE : FR_ACTIVE;
      FR_DECODE: nxt_state = FR_IDLE;
      default:   nxt_state = FR_IDLE;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      state_ff <= FR_IDLE;
    end else if (I_CE) begin
      state_ff <= nxt_state;
    end
  end

  // a frame without clocks leaves the toggle alone and is not decoded
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      tog_seen_ff <= 1'b0;
    end else if (I_CE && state_ff == FR_DECODE) begin
      tog_seen_ff <= tog_sync_ff;
    end
  end

  // frame qualification
  always_comb begin
    dec        = I_CE && state_ff == FR_DECODE;
    fresh      = tog_sync_ff != tog_seen_ff;
    opc_whole  = dec && fresh && fr.byte_cnt != 3'h0;
    aligned    = opc_whole && fr.bit_cnt == 3'h0;
    sector     = fr.addr[SECTOR_LSB +: SECTOR_W];
    tgt_sector = I_TARGET_ADDR[SECTOR_LSB +: SECTOR_W];
  end

  // resume needs no write latch and no running operation
  always_comb begin
    do_resume  = aligned && fr.opcode == OPC_RESUME && run_ff == '0;
    do_suspend = aligned && fr.opcode == OPC_SUSPEND && resume_cnt_ff == '0;
    resume_sel = '0;
    if (do_resume) begin
      if (susp_ff[OP_PROG]) begin
        resume_sel[OP_PROG] = 1'b1;
      end else begin
        resume_sel[OP_ERASE] = susp_ff[OP_ERASE];
      end
    end
    suspend_sel = do_suspend ? run_ff : '0;
    start       = {I_ERASE_START, I_PROG_START};
    done        = {I_ERASE_DONE, I_PROG_DONE};
  end

  // protect is not allowed while any operation sits suspended
  always_comb begin
    prot_seen  = opc_whole && fr.opcode == OPC_PROTECT && susp_ff == '0;
    do_protect = prot_seen && !locked_ff && wel_ff && fr.byte_cnt == BYTE_MAX
                 && fr.bit_cnt == 3'h0;
  end

  // write enable latch
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      wel_ff <= WEL_RESET;
    end else if (prot_seen) begin
      wel_ff <= 1'b0;
    end else if (aligned && fr.opcode == OPC_WR_ENABLE) begin
      wel_ff <= 1'b1;
    end else if (aligned && fr.opcode == OPC_WR_DIS) begin
      wel_ff <= 1'b0;
    end
  end

  // per-operation run and suspend state
  for (genvar g = 0; g < NUM_OPS; g++) begin : g_op
    always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
        run_ff[g]  <= 1'b0;
        susp_ff[g] <= 1'b0;
      end else if (I_CE) begin
        if (start[g]) begin
          run_ff[g] <= 1'b1;
        end else if (done[g]) begin
          run_ff[g] <= 1'b0;
        end else if (suspend_sel[g]) begin
          run_ff[g]  <= 1'b0;
          susp_ff[g] <= 1'b1;
        end else if (resume_sel[g]) begin
          run_ff[g]  <= 1'b1;
          susp_ff[g] <= 1'b0;
        end
      end
    end
  end

  // resume window during which suspend is refused
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      resume_cnt_ff <= '0;
    end else if (I_CE) begin
      if (resume_sel != '0) begin
        resume_cnt_ff <= RESUME_CNT_W'(RESUME_CYCLES);
      end else if (resume_cnt_ff != '0) begin
        resume_cnt_ff <= resume_cnt_ff - 1'b1;
      end
    end
  end

  // one-cycle command pulses to the program and erase engines
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      resume_pls_ff  <= '0;
      suspend_pls_ff <= '0;
    end else if (I_CE) begin
      resume_pls_ff  <= resume_sel;
      suspend_pls_ff <= suspend_sel;
    end
  end

  // protection bits, all protected after reset
  for (genvar s = 0; s < SECTORS; s++) begin : g_sec
    always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
        prot_ff[s] <= PROT_RESET;
      end else if (do_protect && sector == SECTOR_W'(s)) begin
        prot_ff[s] <= 1'b1;
      end
    end
  end

  // program or erase permitted only with latch set and sector unprotected
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      allowed_ff <= 1'b0;
    end else if (I_CE) begin
      allowed_ff <= wel_ff && !prot_ff[tgt_sector];
    end
  end

  // outputs
  assign O_WRITE_ENABLE_LATCH     = wel_ff;
  assign O_PROGRAM_SUSPENDED_FLAG = susp_ff[OP_PROG];
  assign O_ERASE_SUSPENDED_FLAG   = susp_ff[OP_ERASE];
  assign O_READY_BUSY_FLAG        = |run_ff;
  assign O_RESUMING               = resume_cnt_ff != '0;
  assign O_PROG_RESUME            = resume_pls_ff[OP_PROG];
  assign O_ERASE_RESUME           = resume_pls_ff[OP_ERASE];
  assign O_PROG_SUSPEND           = suspend_pls_ff[OP_PROG];
  assign O_ERASE_SUSPEND          = suspend_pls_ff[OP_ERASE];
  assign O_WRITE_ALLOWED          = allowed_ff;
  assign O_PROTECT_BITS           = prot_ff;

  // checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  resume_clears_flag_a: assert property (
    do_resume && susp_ff[OP_PROG] && !start[OP_PROG] && !done[OP_PROG] |=>
      !O_PROGRAM_SUSPENDED_FLAG && O_READY_BUSY_FLAG && O_RESUMING && O_PROG_RESUME)
    else $error("resume did not clear program suspend");

  resume_ignores_wel_a: assert property (
    aligned && fr.opcode == OPC_RESUME && !wel_ff && run_ff == '0 && susp_ff != '0
      && start == '0 |=> O_READY_BUSY_FLAG)
    else $error("resume blocked by clear write latch");

  short_resume_none_a: assert property (
    dec && fr.opcode == OPC_RESUME && fr.bit_cnt != 3'h0 && start == '0
      |=> $stable(susp_ff))
    else $error("misaligned resume changed suspend state");

  prog_first_a: assert property (
    do_resume && susp_ff == 2'b11 && start == '0 && done == '0 |=> O_ERASE_SUSPENDED_FLAG
      && !O_PROGRAM_SUSPENDED_FLAG && O_PROG_RESUME && !O_ERASE_RESUME)
    else $error("erase resumed before program");

  suspend_blocked_a: assert property (
    dec && fr.opcode == OPC_SUSPEND && O_RESUMING && start == '0 && done == '0
      |=> $stable(run_ff) && $stable(susp_ff))
    else $error("suspend taken during resume window");

  resume_window_a: assert property (
    I_CE && resume_sel != '0 |=> O_RESUMING [*8])
    else $error("resume window too short");

  wel_set_a: assert property (
    aligned && fr.opcode == OPC_WR_ENABLE |=> O_WRITE_ENABLE_LATCH)
    else $error("write enable did not set latch");

  wel_keep_a: assert property (
    dec && (fr.opcode == OPC_WR_ENABLE || fr.opcode == OPC_WR_DIS)
      && fr.bit_cnt != 3'h0 |=> $stable(O_WRITE_ENABLE_LATCH))
    else $error("misaligned enable or disable changed latch");

  wel_clear_a: assert property (
    aligned && fr.opcode == OPC_WR_DIS |=> !O_WRITE_ENABLE_LATCH)
    else $error("write disable did not clear latch");

  no_wel_prot_a: assert property (
    dec && !wel_ff |=> $stable(O_PROTECT_BITS))
    else $error("protect executed without write latch");

  reset_prot_a: assert property (
    $rose(I_RST_N) |-> O_PROTECT_BITS == '1 && !O_WRITE_ENABLE_LATCH)
    else $error("protect bits not all set after reset");

  protected_reject_a: assert property (
    I_CE && prot_ff[tgt_sector] |=> !O_WRITE_ALLOWED)
    else $error("write allowed into protected sector");

  protect_sets_a: assert property (
    do_protect |=> O_PROTECT_BITS[sector] && !O_WRITE_ENABLE_LATCH)
    else $error("protect did not set addressed sector");

  short_prot_a: assert property (
    prot_seen && fr.byte_cnt != BYTE_MAX |=> $stable(O_PROTECT_BITS)
      && !O_WRITE_ENABLE_LATCH)
    else $error("short protect not aborted");

  locked_prot_a: assert property (
    prot_seen && locked_ff |=> $stable(O_PROTECT_BITS) && !O_WRITE_ENABLE_LATCH)
    else $error("protect acted while registers locked");

  suspend_sets_a: assert property (
    do_suspend && run_ff[OP_ERASE] && start == '0 && done == '0
      |=> O_ERASE_SUSPENDED_FLAG && !O_READY_BUSY_FLAG && O_ERASE_SUSPEND)
    else $error("suspend did not set erase flag");

  resume_seen_c: cover property (do_resume && susp_ff == 2'b11);
  protect_seen_c: cover property (do_protect);
  wel_cycle_c: cover property (
    aligned && fr.opcode == OPC_WR_ENABLE ##[1:200] aligned && fr.opcode == OPC_WR_DIS);
  suspend_seen_c: cover property (do_suspend && run_ff != '0);
endmodule : flash_wel_protect_resume_cmds

// ---- common/flash_cmd_pkg.sv ----
// constants and types shared by the flash command decoder and its link shifter
package flash_cmd_pkg;
  // opcodes handled by the decoder
  localparam logic [7:0] OPC_RESUME    = 8'hD0;
  localparam logic [7:0] OPC_SUSPEND   = 8'hB0;
  localparam logic [7:0] OPC_WR_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WR_DIS    = 8'h04;
  localparam logic [7:0] OPC_PROTECT   = 8'h36;
  // frame layout: one opcode byte then three address bytes
  localparam int         ADDR_W        = 24;
  localparam int         CNT_W         = 3;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [2:0] BYTE_MAX      = 3'h4;
  // sector map: 64-Kbyte sectors, 32 of them in a 16-megabit array
  localparam int         SECTOR_LSB    = 16;
  localparam int         SECTOR_W      = 5;
  localparam int         NUM_SECTORS   = 32;
  localparam logic       PROT_RESET    = 1'b1;
  localparam logic       WEL_RESET     = 1'b0;
  // operation slots
  localparam int         NUM_OPS       = 2;
  localparam int         OP_PROG       = 0;
  localparam int         OP_ERASE      = 1;
  // timing
  localparam int         SYS_CLK_MHZ       = 125;
  localparam int         RESUME_LATENCY_NS = 20000;
  localparam int         RESUME_CYCLES     = RESUME_LATENCY_NS * SYS_CLK_MHZ / 1000;
  localparam int         RESUME_CNT_W      = 12;
  // frame tracking, gray along idle -> active -> decode
  typedef enum logic [1:0] {
    FR_IDLE   = 2'b00,
    FR_ACTIVE = 2'b01,
    FR_DECODE = 2'b11
  } frame_t;
endpackage : flash_cmd_pkg

// ---- common/frame_if.sv ----
// captured frame fields passed from the serial-clock shifter to the decoder
`timescale 1ns/100ps
interface frame_if import flash_cmd_pkg::*; ();
  logic [7:0]        opcode;
  logic [ADDR_W-1:0] addr;
  logic [CNT_W-1:0]  bit_cnt;
  logic [CNT_W-1:0]  byte_cnt;
  logic              frame_tog;
  modport link (output opcode, output addr, output bit_cnt, output byte_cnt, output frame_tog);
  modport core (input opcode, input addr, input bit_cnt, input byte_cnt, input frame_tog);
endinterface : frame_if

// ---- logic/spi_frame_shifter.sv ----
// serial-clock side: shifts the frame in and holds opcode, address and counts
`timescale 1ns/100ps
module spi_frame_shifter
  import flash_cmd_pkg::*;
(
  input  wire logic i_sck,
  input  wire logic i_cs_n,
  input  wire logic i_mosi,
  input  wire logic i_rst_n,
  frame_if.link     lnk
);
  logic              first_ff;
  logic [7:0]        shift_ff;
  logic [CNT_W-1:0]  bit_ff;
  logic [CNT_W-1:0]  byte_ff;
  logic [7:0]        opcode_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic              tog_ff;
  logic [CNT_W-1:0]  cur_bit;
  logic [CNT_W-1:0]  cur_byte;
  logic [7:0]        nxt_shift;

  // armed while chip select is high or reset is low, so the first edge of a frame restarts counts
  always_ff @(posedge i_sck or posedge i_cs_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_ff <= 1'b1;
    end else if (i_cs_n) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end

  // counts as seen by this edge
  always_comb begin
    cur_bit   = first_ff ? '0 : bit_ff;
    cur_byte  = first_ff ? '0 : byte_ff;
    nxt_shift = {shift_ff[6:0], i_mosi};
  end

  // mosi sampled on the rising edge, modes 0 and 3
  always_ff @(posedge i_sck) begin
    shift_ff <= nxt_shift;
    bit_ff   <= cur_bit + 3'h1;
    if (cur_bit == BIT_LAST) begin
      byte_ff <= (cur_byte == BYTE_MAX) ? BYTE_MAX : cur_byte + 3'h1;
    end else begin
      byte_ff <= cur_byte;
    end
  end

  // opcode is the first byte, then three address bytes, later bytes dropped
  always_ff @(posedge i_sck) begin
    if (cur_bit == BIT_LAST && cur_byte == 3'h0) begin
      opcode_ff <= nxt_shift;
    end
    if (cur_bit == BIT_LAST && cur_byte != 3'h0 && cur_byte != BYTE_MAX) begin
      addr_ff <= {addr_ff[15:0], nxt_shift};
    end
  end

  // one toggle per frame tells the decoder the fields are new
  always_ff @(posedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tog_ff <= 1'b0;
    end else if (first_ff) begin
      tog_ff <= ~tog_ff;
    end
  end

  assign lnk.opcode    = opcode_ff;
  assign lnk.addr      = addr_ff;
  assign lnk.bit_cnt   = bit_ff;
  assign lnk.byte_cnt  = byte_ff;
  assign lnk.frame_tog = tog_ff;
endmodule : spi_frame_shifter

// ---- verification/spi_host_model.sv ----
// spi host model that frames flash commands in mode 0 on its own serial clock
`timescale 1ns/100ps
module spi_host_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi
);
  // serial clock stands still and chip select is idle between frames
  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // one frame of nbits bits, msb first, 6 ns serial period, phase offset from system clock
  task automatic frame(input logic [39:0] data, input int nbits);
    #1.3;
    o_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_mosi = data[39-i];
      #3 o_sck = 1'b1;
      #3 o_sck = 1'b0;
    end
    #3 o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // released line must not keep showing the last bit
  endtask : frame
endmodule : spi_host_model

// ---- verification/flash_wel_protect_resume_cmds_tb.sv ----
// self-checking bench for the write-enable, protect, suspend and resume decoder
`timescale 1ns/100ps
module flash_wel_protect_resume_cmds_tb;
  import flash_cmd_pkg::*;
  logic              clk;
  logic              rst_n;
  logic              sck;
  logic              cs_n;
  logic              mosi;
  logic              locked;
  logic              prog_start;
  logic              erase_start;
  logic              prog_done;
  logic              erase_done;
  logic [ADDR_W-1:0] target_addr;
  logic              wel;
  logic              ps_flag;
  logic              es_flag;
  logic              busy;
  logic              resuming;
  logic              prog_res;
  logic              erase_res;
  logic              prog_susp;
  logic              erase_susp;
  logic              write_ok;
  logic [31:0]       prot;
  int                mismatches;
  int                n_compared;
  int                cycles;
  int                n_prog_res;
  int                n_erase_res;
  int                n_prog_susp;
  int                n_erase_susp;

  flash_wel_protect_resume_cmds #(.SECTORS(32)) u_flash_wel_protect_resume_cmds (
    .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_SPI_SCK(sck), .I_SPI_CS_N(cs_n),
    .I_SPI_MOSI(mosi), .I_PROTECTION_REGS_LOCKED(locked), .I_PROG_START(prog_start),
    .I_ERASE_START(erase_start), .I_PROG_DONE(prog_done), .I_ERASE_DONE(erase_done),
    .I_TARGET_ADDR(target_addr), .O_WRITE_ENABLE_LATCH(wel), .O_PROGRAM_SUSPENDED_FLAG(ps_flag),
    .O_ERASE_SUSPENDED_FLAG(es_flag), .O_READY_BUSY_FLAG(busy), .O_RESUMING(resuming),
    .O_PROG_RESUME(prog_res), .O_ERASE_RESUME(erase_res), .O_PROG_SUSPEND(prog_susp),
    .O_ERASE_SUSPEND(erase_susp), .O_WRITE_ALLOWED(write_ok), .O_PROTECT_BITS(prot));

  spi_host_model u_spi_host_model (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));

  // system clock, 8 ns period
  always #4 clk = ~clk;

  // engine pulse counters and the hang limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (prog_res === 1'b1) n_prog_res <= n_prog_res + 1;
    if (erase_res === 1'b1) n_erase_res <= n_erase_res + 1;
    if (prog_susp === 1'b1) n_prog_susp <= n_prog_susp + 1;
    if (erase_susp === 1'b1) n_erase_susp <= n_erase_susp + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // one framed command, then enough system edges for its effect to land
  task automatic cmd(input logic [39:0] data, input int nbits);
    @(negedge clk);
    u_spi_host_model.frame(data, nbits);
    cyc(8);
  endtask : cmd

  task automatic engine(input int which, input logic v);
    case (which)
      0: prog_start = v;
      1: erase_start = v;
      2: prog_done = v;
      default: erase_done = v;
    endcase
  endtask : engine

  task automatic pulse(input int which);
    @(negedge clk);
    engine(which, 1'b1);
    @(negedge clk);
    engine(which, 1'b0);
    cyc(2);
  endtask : pulse

  // wait out the resume window under a bound
  task automatic wait_resume_done();
    for (int i = 0; i < 3000 && resuming !== 1'b0; i++) cyc(1);
    check(resuming, 0);
  endtask : wait_resume_done

  task automatic t_reset();
    check(wel, 0);
    check({ps_flag, es_flag, busy}, 0);
    check(prot, 32'hFFFFFFFF);
  endtask : t_reset

  task automatic t_latch();
    cmd({OPC_WR_ENABLE, 8'hA5, 24'h000000}, 16);
    check(wel, 1);
    target_addr = 24'h0A1234;
    cyc(2);
    check(write_ok, 0);
    cmd({OPC_WR_DIS, 32'h00000000}, 12);
    check(wel, 1);
    cmd({OPC_WR_DIS, 32'h00000000}, 5);
    check(wel, 1);
    cmd({OPC_WR_DIS, 8'h3C, 24'h000000}, 16);
    check(wel, 0);
    cmd({OPC_WR_ENABLE, 32'h00000000}, 7);
    check(wel, 0);
  endtask : t_latch

  // full, short, misaligned and locked protect frames all leave the latch clear
  task automatic t_protect();
    logic [39:0] pf;
    int          nb [4];
    pf = {OPC_PROTECT, 24'h150000, 8'hFF};
    nb = '{40, 24, 30, 32};
    for (int k = 0; k < 4; k++) begin
      locked = (k == 3);
      cmd({OPC_WR_ENABLE, 32'h00000000}, 8);
      check(wel, 1);
      cmd(pf, nb[k]);
      check(wel, 0);
      check(prot, 32'hFFFFFFFF);
    end
    locked = 1'b0;
  endtask : t_protect

  task automatic t_suspend_resume();
    pulse(0);
    check(busy, 1);
    cmd({OPC_SUSPEND, 32'h00000000}, 8);
    check({ps_flag, busy, n_prog_susp[0]}, 3'h5);
    cmd({OPC_RESUME, 32'h00000000}, 12);
    check(ps_flag, 1);
    check(wel, 0);
    cmd({OPC_RESUME, 8'h77, 24'h000000}, 16);
    check({ps_flag, busy, resuming}, 3'h3);
    check(n_prog_res, 1);
    cmd({OPC_SUSPEND, 32'h00000000}, 8);
    check({ps_flag, busy}, 2'h1);
    wait_resume_done();
    cmd({OPC_SUSPEND, 32'h00000000}, 8);
    check({ps_flag, busy}, 2'h2);
  endtask : t_suspend_resume

  // program and erase suspended together: program resumes first
  task automatic t_both();
    pulse(1);
    cmd({OPC_SUSPEND, 32'h00000000}, 8);
    check({ps_flag, es_flag, busy}, 3'h6);
    check(n_erase_susp, 1);
    cmd({OPC_RESUME, 32'h00000000}, 8);
    check({ps_flag, es_flag, busy}, 3'h3);
    check({n_prog_res[7:0], n_erase_res[7:0]}, 16'h0200);
    wait_resume_done();
    pulse(2);
    check(busy, 0);
    cmd({OPC_RESUME, 32'h00000000}, 8);
    check({ps_flag, es_flag, busy}, 3'h1);
    check(n_erase_res, 1);
    pulse(3);
    check(busy, 0);
  endtask : t_both

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // reset for 10 cycles, then the scenarios in order
  initial begin
    clk = 1'b0;
    rst_n = 1'b1;
    locked = 1'b0;
    {prog_start, erase_start, prog_done, erase_done} = 4'h0;
    target_addr = 24'h000000;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    n_prog_res = 0;
    n_erase_res = 0;
    n_prog_susp = 0;
    n_erase_susp = 0;
    // reset falls after time zero so the link-side flops see a clean edge
    #1 rst_n = 1'b0;
    cyc(10);
    rst_n = 1'b1;
    cyc(5);
    t_reset();
    t_latch();
    t_protect();
    t_suspend_resume();
    t_both();
    report_and_stop();
  end
endmodule : flash_wel_protect_resume_cmds_tb
